// File: core/cell_balance_controller.sv
/*
 Cell balance controller: registers over AHB-Lite, sampling, mean and
 per-bank selection with hysteresis, on-time and relaxation timing.
 Assumes a CAN receiver outside that writes the registers on behalf of
 the master, and an ADC front end delivering sample_valid_i/sample_data_i.
*/
// Chosen here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
// How it works
// - Idle until monitor command, then sample
// - Stored cell voltages readable on request
// - Mean computed, furthest deviation found
// - Below threshold: monitor only, no current
// - Beyond threshold: per bank, charge furthest cell if low, discharge if high
// - Keep balancing furthest cell until within
// - Two bank channels run concurrently
// - Banks are cells 0-7 and 8-14
// - Settled bank idles, resumes past threshold
// - Oversampled sampling starts each cycle
// - Apply action for configured on-time
// - Relax time shortened by sampling time
// - Forward threshold smaller than reverse
// - Reversal makes new direction the forward
// - Both thresholds are configurable
// - Same direction beyond forward: select again
// - Opposite below reverse: no action
// - Parameters written and applied by master
// - Control commands obeyed only for own board identifier
module cell_balance_controller
	import cell_balance_pkg::*;
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// AHB-Lite slave
	input wire logic hsel_i,
	input wire logic [31:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	// Measurement front end
	output logic [cell_balance_pkg::CELL_AW-1:0] sample_cell_o,
	output logic sample_req_o,
	input wire logic sample_valid_i,
	input wire logic [cell_balance_pkg::VOLT_W-1:0] sample_data_i,
	// Balancing engine, one channel per bank
	output logic low_en_o,
	output logic [cell_balance_pkg::CELL_AW-1:0] low_cell_o,
	output logic low_charge_o,
	output logic up_en_o,
	output logic [cell_balance_pkg::CELL_AW-1:0] up_cell_o,
	output logic up_charge_o
);
	import cell_balance_pkg::*;

	typedef enum logic [2:0] {ST_OFF, ST_SAMPLE, ST_MEAN, ST_SELECT, ST_ON, ST_RELAX} state_t;

	// ****************************************
	// Registers and bus slave
	// ****************************************
	state_t state_reg;
	logic mon_reg, bal_reg;
	logic [VOLT_W-1:0] fwd_th_reg, rev_th_reg;
	logic [6:0] ovs_reg;
	logic [15:0] on_time_reg, relax_reg;
	logic [BOARD_ID_W-1:0] board_id_reg;
	logic [VOLT_W-1:0] mean_reg;
	logic dphase_reg, dwrite_reg, drd_pend_reg;
	logic [7:0] daddr_reg;
	logic [VOLT_W-1:0] mem_rdata;
	logic addr_ok;
	logic [CELL_AW-1:0] rd_cell;

	assign addr_ok = hsel_i && hready_i && htrans_i[1];
	assign rd_cell = CELL_AW'((haddr_i[7:0] - CELL_BASE_OFS) >> 2);

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			dphase_reg <= 1'b0;
			dwrite_reg <= 1'b0;
			daddr_reg <= '0;
		end else if (hready_i) begin
			dphase_reg <= addr_ok;
			dwrite_reg <= addr_ok && hwrite_i;
			daddr_reg <= haddr_i[7:0];
		end
	end

	logic id_match;
	assign id_match = hwdata_i[CTRL_ID_LSB +: BOARD_ID_W] == board_id_reg;
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			mon_reg <= 1'b0;
			bal_reg <= 1'b0;
			fwd_th_reg <= FWD_TH_RST;
			rev_th_reg <= REV_TH_RST;
			ovs_reg <= OVS_RST;
			on_time_reg <= ON_TIME_RST;
			relax_reg <= RELAX_RST;
			board_id_reg <= BOARD_ID_RST;
		end else if (dphase_reg && dwrite_reg) begin
			case (daddr_reg)
				CTRL_OFS: begin
					if (id_match) begin
						mon_reg <= hwdata_i[CTRL_MON_BIT] | hwdata_i[CTRL_BAL_BIT];
						bal_reg <= hwdata_i[CTRL_BAL_BIT];
					end
				end
				FWD_TH_OFS: fwd_th_reg <= hwdata_i[VOLT_W-1:0];
				REV_TH_OFS: rev_th_reg <= hwdata_i[VOLT_W-1:0];
				OVS_OFS: ovs_reg <= (hwdata_i[6:0] == 7'h00) ? 7'h01 : hwdata_i[6:0];
				ON_TIME_OFS: on_time_reg <= hwdata_i[15:0];
				RELAX_OFS: relax_reg <= hwdata_i[15:0];
				BOARD_ID_OFS: board_id_reg <= hwdata_i[BOARD_ID_W-1:0];
				default: begin
				end
			endcase
		end
	end

	// Reads take one wait state for cell memory
	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			drd_pend_reg <= 1'b0;
			hreadyout_o <= 1'b1;
			hrdata_o <= '0;
			hresp_o <= 1'b0;
		end else if (addr_ok && !hwrite_i) begin
			drd_pend_reg <= 1'b1;
			hreadyout_o <= 1'b0;
		end else if (drd_pend_reg) begin
			drd_pend_reg <= 1'b0;
			hreadyout_o <= 1'b1;
			case (daddr_reg)
				CTRL_OFS: hrdata_o <= {16'h0000, board_id_reg, 6'h00, bal_reg, mon_reg};
				FWD_TH_OFS: hrdata_o <= {16'h0000, fwd_th_reg};
				REV_TH_OFS: hrdata_o <= {16'h0000, rev_th_reg};
				OVS_OFS: hrdata_o <= {25'h0000000, ovs_reg};
				ON_TIME_OFS: hrdata_o <= {16'h0000, on_time_reg};
				RELAX_OFS: hrdata_o <= {16'h0000, relax_reg};
				STATUS_OFS: hrdata_o <= {29'h00000000, 3'(state_reg)};
				MEAN_OFS: hrdata_o <= {16'h0000, mean_reg};
				BOARD_ID_OFS: hrdata_o <= {24'h000000, board_id_reg};
				default: begin
					if (daddr_reg >= CELL_BASE_OFS && daddr_reg < CELL_BASE_OFS + 8'(4 * NUM_CELLS)) begin
						hrdata_o <= {16'h0000, mem_rdata};
					end else begin
						hrdata_o <= '0;
					end
				end
			endcase
		end
	end

	// ****************************************
	// Timebase and cell store
	// ****************************************
	logic tick;
	tick_divider i_tick_divider (
		.clock_i(clock_i),
		.rst_i(rst_i),
		.tick_o(tick)
	);

	logic [CELL_AW-1:0] cell_reg;
	logic [6:0] ovs_cnt_reg;
	logic [VOLT_W+6:0] acc_reg;
	logic store_en;
	logic [VOLT_W-1:0] store_val;
	logic [VOLT_W-1:0] avg_volt [0:NUM_CELLS-1];

	assign store_en = state_reg == ST_SAMPLE && sample_valid_i && ovs_cnt_reg == ovs_reg - 7'h01;
	assign store_val = VOLT_W'(({7'h00, acc_reg} + {7'h00, sample_data_i}) / ovs_reg);

	cell_volt_mem i_cell_volt_mem (
		.clock_i(clock_i),
		.wr_en_i(store_en),
		.wr_addr_i(cell_reg),
		.wr_data_i(store_val),
		.rd_addr_i(rd_cell),
		.rd_data_o(mem_rdata)
	);

	// Working copy of averages used by selection
	always_ff @(posedge clock_i) begin
		if (store_en) begin
			avg_volt[cell_reg] <= store_val;
		end
	end

	// ****************************************
	// Cycle sequencer
	// ****************************************
	logic [15:0] time_reg;
	logic [15:0] samp_ms_reg;
	logic [SUM_W-1:0] sum_reg;
	logic [15:0] relax_left;

	assign relax_left = (relax_reg > samp_ms_reg) ? relax_reg - samp_ms_reg : 16'h0000;

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			state_reg <= ST_OFF;
			cell_reg <= '0;
			ovs_cnt_reg <= '0;
			acc_reg <= '0;
			time_reg <= '0;
			samp_ms_reg <= '0;
			sum_reg <= '0;
			mean_reg <= '0;
			sample_req_o <= 1'b0;
			sample_cell_o <= '0;
		end else begin
			case (state_reg)
				ST_OFF: begin
					if (mon_reg) begin
						state_reg <= ST_SAMPLE;
						cell_reg <= '0;
						ovs_cnt_reg <= '0;
						acc_reg <= '0;
						sum_reg <= '0;
						sample_req_o <= 1'b1;
						sample_cell_o <= '0;
					end
				end
				ST_SAMPLE: begin
					if (sample_valid_i) begin
						if (ovs_cnt_reg == ovs_reg - 7'h01) begin
							ovs_cnt_reg <= '0;
							acc_reg <= '0;
							sum_reg <= sum_reg + SUM_W'(store_val);
							if (cell_reg == CELL_AW'(NUM_CELLS - 1)) begin
								state_reg <= ST_MEAN;
								sample_req_o <= 1'b0;
							end else begin
								cell_reg <= cell_reg + 4'h1;
								sample_cell_o <= cell_reg + 4'h1;
							end
						end else begin
							ovs_cnt_reg <= ovs_cnt_reg + 7'h01;
							acc_reg <= acc_reg + 23'(sample_data_i);
						end
					end
				end
				ST_MEAN: begin
					mean_reg <= VOLT_W'(sum_reg / SUM_W'(NUM_CELLS));
					samp_ms_reg <= 16'(ovs_reg) * SAMPLE_MS_PER_OVS;
					state_reg <= bal_reg ? ST_SELECT : ST_OFF;
				end
				ST_SELECT: begin
					state_reg <= ST_ON;
					time_reg <= '0;
				end
				ST_ON: begin
					if (!mon_reg) begin
						state_reg <= ST_OFF;
					end else if (tick) begin
						if (time_reg + 16'h0001 >= on_time_reg) begin
							state_reg <= ST_RELAX;
							time_reg <= '0;
						end else begin
							time_reg <= time_reg + 16'h0001;
						end
					end
				end
				ST_RELAX: begin
					if (!mon_reg) begin
						state_reg <= ST_OFF;
					end else if (time_reg >= relax_left) begin
						state_reg <= ST_OFF;
					end else if (tick) begin
						time_reg <= time_reg + 16'h0001;
					end
				end
				default: state_reg <= ST_OFF;
			endcase
		end
	end

	// ****************************************
	// Per-bank selection with hysteresis
	// ****************************************
	function automatic logic [VOLT_W:0] deviation(input logic [VOLT_W-1:0] v, input logic [VOLT_W-1:0] m);
		deviation = (v >= m) ? {1'b1, v - m} : {1'b0, m - v};
	endfunction

	logic [CELL_AW-1:0] bank_first [0:1];
	logic [CELL_AW-1:0] bank_last [0:1];
	logic bank_en [0:1];
	logic [CELL_AW-1:0] bank_cell [0:1];
	logic bank_chg [0:1];
	assign bank_first[0] = LOW_FIRST;
	assign bank_last[0] = LOW_LAST;
	assign bank_first[1] = UP_FIRST;
	assign bank_last[1] = UP_LAST;

	for (genvar b = 0; b < 2; b++) begin : g_bank
		logic [CELL_AW-1:0] best;
		logic [VOLT_W-1:0] best_mag;
		logic best_high;
		logic [VOLT_W:0] d;
		dir_t last_dir_reg [0:NUM_CELLS-1];
		dir_t want, prev;
		logic pass;

		always_comb begin
			best = bank_first[b];
			best_mag = '0;
			best_high = 1'b0;
			d = '0;
			for (int i = 0; i < NUM_CELLS; i++) begin
				d = deviation(avg_volt[i], mean_reg);
				if (CELL_AW'(i) >= bank_first[b] && CELL_AW'(i) <= bank_last[b] && d[VOLT_W-1:0] > best_mag) begin
					best = CELL_AW'(i);
					best_mag = d[VOLT_W-1:0];
					best_high = d[VOLT_W];
				end
			end
		end

		assign want = best_high ? DIR_DISCHARGE : DIR_CHARGE;
		assign prev = last_dir_reg[best];
		assign pass = (prev == DIR_NONE || prev == want) ? best_mag > fwd_th_reg : best_mag > rev_th_reg;

		always_ff @(posedge clock_i) begin
			if (rst_i) begin
				bank_en[b] <= 1'b0;
				bank_cell[b] <= bank_first[b];
				bank_chg[b] <= 1'b0;
			end else if (state_reg == ST_SELECT) begin
				bank_en[b] <= pass;
				bank_cell[b] <= best;
				bank_chg[b] <= want == DIR_CHARGE;
			end else if (state_reg != ST_ON) begin
				bank_en[b] <= 1'b0;
			end
		end

		always_ff @(posedge clock_i) begin
			if (rst_i) begin
				for (int i = 0; i < NUM_CELLS; i++) begin
					last_dir_reg[i] <= DIR_NONE;
				end
			end else if (state_reg == ST_SELECT && pass) begin
				last_dir_reg[best] <= want;
			end
		end
	end

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			low_en_o <= 1'b0;
			low_cell_o <= LOW_FIRST;
			low_charge_o <= 1'b0;
			up_en_o <= 1'b0;
			up_cell_o <= UP_FIRST;
			up_charge_o <= 1'b0;
		end else begin
			low_en_o <= bank_en[0] && state_reg == ST_ON;
			low_cell_o <= bank_cell[0];
			low_charge_o <= bank_chg[0];
			up_en_o <= bank_en[1] && state_reg == ST_ON;
			up_cell_o <= bank_cell[1];
			up_charge_o <= bank_chg[1];
		end
	end
endmodule

// File: core/cell_balance_pkg.sv
/*
 Shared constants for the cell balance controller: cell count, bank split,
 register map, reset values, timing and command codes.
 Assumes a 100 MHz clock and word-aligned 32-bit AHB-Lite register access.
*/
package cell_balance_pkg;
	localparam int NUM_CELLS = 15;
	localparam int CELL_AW = 4;
	localparam int VOLT_W = 16;
	localparam int SUM_W = 32;
	localparam logic [CELL_AW-1:0] LOW_FIRST = 4'h0;
	localparam logic [CELL_AW-1:0] LOW_LAST = 4'h7;
	localparam logic [CELL_AW-1:0] UP_FIRST = 4'h8;
	localparam logic [CELL_AW-1:0] UP_LAST = 4'he;
	localparam int CLK_MHZ = 100;
	localparam int TICK_US = 1000;
	localparam int TICK_CYCLES = CLK_MHZ * TICK_US;
	// Register byte offsets
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] FWD_TH_OFS = 8'h04;
	localparam logic [7:0] REV_TH_OFS = 8'h08;
	localparam logic [7:0] OVS_OFS = 8'h0c;
	localparam logic [7:0] ON_TIME_OFS = 8'h10;
	localparam logic [7:0] RELAX_OFS = 8'h14;
	localparam logic [7:0] STATUS_OFS = 8'h18;
	localparam logic [7:0] MEAN_OFS = 8'h1c;
	localparam logic [7:0] BOARD_ID_OFS = 8'h20;
	localparam logic [7:0] CELL_BASE_OFS = 8'h40;
	// Control fields
	localparam int CTRL_MON_BIT = 0;
	localparam int CTRL_BAL_BIT = 1;
	localparam int CTRL_ID_LSB = 8;
	localparam int BOARD_ID_W = 8;
	// Reset values
	localparam logic [VOLT_W-1:0] FWD_TH_RST = 16'h0002;
	localparam logic [VOLT_W-1:0] REV_TH_RST = 16'h0004;
	localparam logic [6:0] OVS_RST = 7'h20;
	localparam logic [15:0] ON_TIME_RST = 16'h0064;
	localparam logic [15:0] RELAX_RST = 16'h00c8;
	localparam logic [BOARD_ID_W-1:0] BOARD_ID_RST = 8'h01;
	// Sampling time per oversample, in milliseconds of ticks
	localparam logic [15:0] SAMPLE_MS_PER_OVS = 16'h0002;
	typedef enum logic [1:0] {DIR_NONE, DIR_CHARGE, DIR_DISCHARGE} dir_t;
endpackage

// File: core/cell_volt_mem.sv
/*
 Little memory holding the latest voltage of every cell.
 Assumes one write and one registered read per cycle.
*/
`timescale 1ns/1ps
module cell_volt_mem
	import cell_balance_pkg::*;
(
	// Clock
	input wire logic clock_i,
	// Write side
	input wire logic wr_en_i,
	input wire logic [cell_balance_pkg::CELL_AW-1:0] wr_addr_i,
	input wire logic [cell_balance_pkg::VOLT_W-1:0] wr_data_i,
	// Read side
	input wire logic [cell_balance_pkg::CELL_AW-1:0] rd_addr_i,
	output logic [cell_balance_pkg::VOLT_W-1:0] rd_data_o
);
	logic [VOLT_W-1:0] mem [0:NUM_CELLS-1];

	always_ff @(posedge clock_i) begin
		if (wr_en_i) begin
			mem[wr_addr_i] <= wr_data_i;
		end
	end

	always_ff @(posedge clock_i) begin
		if (rd_addr_i < CELL_AW'(NUM_CELLS)) begin
			rd_data_o <= mem[rd_addr_i];
		end else begin
			rd_data_o <= '0;
		end
	end
endmodule

// File: core/tick_divider.sv
/*
 Millisecond enable divider.
 Assumes the 100 MHz system clock; emits a one-cycle pulse per tick.
*/
`timescale 1ns/1ps
module tick_divider
	import cell_balance_pkg::*;
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// Tick
	output logic tick_o
);
	logic [16:0] count_reg;

	always_ff @(posedge clock_i) begin
		if (rst_i) begin
			count_reg <= '0;
			tick_o <= 1'b0;
		end else if (count_reg == 17'(TICK_CYCLES - 1)) begin
			count_reg <= '0;
			tick_o <= 1'b1;
		end else begin
			count_reg <= count_reg + 17'h00001;
			tick_o <= 1'b0;
		end
	end
endmodule

// File: test/balance_ctrl_props.sv
/*
 Checker for the cell balance controller: bus timing, bank ranges, sampling.
 Sees the controller's top ports only; bound to every controller instance.
*/
`timescale 1ns/1ps
module balance_ctrl_props
	import cell_balance_pkg::*;
(
	// Watched ports
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic hsel_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic hready_i,
	input wire logic hreadyout_o,
	input wire logic hresp_o,
	input wire logic sample_req_o,
	input wire logic [cell_balance_pkg::CELL_AW-1:0] sample_cell_o,
	input wire logic low_en_o,
	input wire logic [cell_balance_pkg::CELL_AW-1:0] low_cell_o,
	input wire logic low_charge_o,
	input wire logic up_en_o,
	input wire logic [cell_balance_pkg::CELL_AW-1:0] up_cell_o
);
	//****************
	// Properties
	//****************
	logic take;
	assign take = hsel_i && hready_i && htrans_i[1];
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);
	AST_RD_WAIT: assert property (take && !hwrite_i |=> !hreadyout_o ##1 hreadyout_o)
		else $error("read wait state wrong");
	AST_WR_NOWAIT: assert property (take && hwrite_i |=> hreadyout_o)
		else $error("write stalled");
	AST_OKAY: assert property (hresp_o == 1'b0)
		else $error("response not okay");
	AST_LOW_BANK: assert property (low_en_o |-> low_cell_o <= LOW_LAST)
		else $error("low channel outside its bank");
	AST_UP_BANK: assert property (up_en_o |-> up_cell_o >= UP_FIRST && up_cell_o <= UP_LAST)
		else $error("upper channel outside its bank");
	AST_SAMPLE_QUIET: assert property (sample_req_o |-> !(low_en_o || up_en_o))
		else $error("current flows while sampling");
	AST_SAMPLE_RANGE: assert property (sample_req_o |-> sample_cell_o <= UP_LAST)
		else $error("sampled cell out of range");
	AST_HOLD_SEL: assert property (low_en_o && $past(low_en_o) |-> $stable({low_cell_o, low_charge_o}))
		else $error("selection changed during on-time");
	AST_RESET_QUIET: assert property ($past(rst_i) |-> !low_en_o && !up_en_o && !sample_req_o && hreadyout_o)
		else $error("not idle after reset");
	cover property ($rose(low_en_o));
	cover property ($rose(up_en_o));
	cover property (take && !hwrite_i);
endmodule
bind cell_balance_controller balance_ctrl_props i_balance_ctrl_props (.clock_i(clock_i), .rst_i(rst_i),
	.hsel_i(hsel_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hready_i(hready_i), .hreadyout_o(hreadyout_o),
	.hresp_o(hresp_o), .sample_req_o(sample_req_o), .sample_cell_o(sample_cell_o), .low_en_o(low_en_o),
	.low_cell_o(low_cell_o), .low_charge_o(low_charge_o), .up_en_o(up_en_o), .up_cell_o(up_cell_o));

// File: test/adc_front_model.sv
/*
 Measurement front end model: answers each sampling request with a pulse.
 Assumes the controller holds sample_cell_o steady until a sample is given.
*/
`timescale 1ns/1ps
module adc_front_model
	import cell_balance_pkg::*;
(
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_i,
	// Controller side
	input wire logic sample_req_i,
	input wire logic [cell_balance_pkg::CELL_AW-1:0] sample_cell_i,
	input wire logic [cell_balance_pkg::NUM_CELLS*cell_balance_pkg::VOLT_W-1:0] volts_i,
	output logic sample_valid_o,
	output logic [cell_balance_pkg::VOLT_W-1:0] sample_data_o
);
	logic [1:0] gap;
	initial begin
		sample_valid_o = 1'b0;
		sample_data_o = 16'h0;
		gap = 2'h2;
	end
	// Random gaps; data line scrambled outside a pulse
	always @(posedge clock_i) begin
		if (rst_i || !sample_req_i) begin
			sample_valid_o <= 1'b0;
			sample_data_o <= ~sample_data_o;
			gap <= 2'h2;
		end else if (sample_valid_o) begin
			sample_valid_o <= 1'b0;
			sample_data_o <= ~sample_data_o;
		end else if (gap != 2'h0) begin
			sample_valid_o <= 1'b0;
			sample_data_o <= ~sample_data_o;
			gap <= gap - 2'h1;
		end else begin
			sample_valid_o <= 1'b1;
			sample_data_o <= volts_i[sample_cell_i*VOLT_W +: VOLT_W];
			gap <= 2'($urandom_range(3, 1));
		end
	end
endmodule

// File: test/cell_balance_controller_tb_top.sv
/*
 Self-checking bench: register reads over AHB-Lite, monitoring, balancing.
 Assumes the front end model in place of the measurement circuitry.
*/
`timescale 1ns/1ps
module cell_balance_controller_tb_top;
	import cell_balance_pkg::*;
	logic clock_i, rst_i, hsel_i, hwrite_i, hready_i, hreadyout_o, hresp_o, sample_req_o, sample_valid_i;
	logic low_en_o, low_charge_o, up_en_o, up_charge_o, lo_was, up_was, rd_ph;
	logic [31:0] haddr_i, hwdata_i, hrdata_o;
	logic [1:0] htrans_i;
	logic [2:0] hsize_i;
	logic [3:0] sample_cell_o, low_cell_o, up_cell_o;
	logic [15:0] sample_data_i, base;
	logic [NUM_CELLS*VOLT_W-1:0] volts;
	logic [31:0] rd_q[$], lo_q[$], up_q[$];
	int num_errors, check_count, i;
	assign hready_i = hreadyout_o;
	always #5 clock_i = ~clock_i;
	cell_balance_controller i_cell_balance_controller (.clock_i(clock_i), .rst_i(rst_i), .hsel_i(hsel_i),
		.haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i),
		.hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
		.sample_cell_o(sample_cell_o), .sample_req_o(sample_req_o), .sample_valid_i(sample_valid_i),
		.sample_data_i(sample_data_i), .low_en_o(low_en_o), .low_cell_o(low_cell_o), .low_charge_o(low_charge_o),
		.up_en_o(up_en_o), .up_cell_o(up_cell_o), .up_charge_o(up_charge_o));
	adc_front_model i_adc_front_model (.clock_i(clock_i), .rst_i(rst_i), .sample_req_i(sample_req_o),
		.sample_cell_i(sample_cell_o), .volts_i(volts), .sample_valid_o(sample_valid_i), .sample_data_o(sample_data_i));
	//****************
	// Tasks
	//****************
	task automatic test_done();
		$display("checks %0d errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	function automatic logic sig(input int w);
		return w == 0 ? sample_req_o : (w == 1 ? low_en_o : (w == 2 ? up_en_o : hreadyout_o));
	endfunction
	task automatic wait_sig(input int w, input logic v, input int lim);
		int n;
		n = 0;
		do begin
			@(posedge clock_i);
			n++;
		end while (sig(w) !== v && n < lim);
		if (sig(w) !== v) begin
			num_errors++;
			$display("CHECK FAILED wait %0d expected %b seen timeout", w, v);
			test_done();
		end
	endtask
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel_i <= 1'b1;
		htrans_i <= 2'b10;
		hwrite_i <= wr;
		haddr_i <= {24'h0, a};
		if (!wr)
			rd_q.push_back(d);
		wait_sig(3, 1'b1, 50);
		htrans_i <= 2'b00;
		hwdata_i <= d;
		wait_sig(3, 1'b1, 50);
	endtask
	task automatic set_v(input int c, input int dv);
		volts[c*VOLT_W +: VOLT_W] <= 16'(base + dv);
	endtask
	task automatic sweep_end();
		wait_sig(0, 1'b1, 2000);
		wait_sig(0, 1'b0, 2000);
		for (i = 0; i < NUM_CELLS; i++)
			set_v(i, 0);
	endtask
	// Stop an on-time or relax phase at once and start a fresh balance cycle
	task automatic rerun_cycle();
		bus(1'b1, CTRL_OFS, 32'h0100);
		bus(1'b1, CTRL_OFS, 32'h0103);
	endtask
	//****************
	// Result watcher
	//****************
	always @(posedge clock_i) begin
		if (rst_i)
			rd_ph <= 1'b0;
		else begin
			if (rd_ph && hreadyout_o)
				check("hrdata", hrdata_o, rd_q.size() ? rd_q.pop_front() : 32'hffff_ffff);
			if (hreadyout_o)
				rd_ph <= hsel_i && htrans_i[1] && !hwrite_i;
			if (low_en_o === 1'b1 && !lo_was)
				check("low pick", {low_cell_o, low_charge_o}, lo_q.size() ? lo_q.pop_front() : 32'hffff_ffff);
			if (up_en_o === 1'b1 && !up_was)
				check("up pick", {up_cell_o, up_charge_o}, up_q.size() ? up_q.pop_front() : 32'hffff_ffff);
		end
		lo_was <= low_en_o;
		up_was <= up_en_o;
	end
	//****************
	// Sequence
	//****************
	initial begin
		void'($urandom(32'h499977d7));
		clock_i = 1'b0;
		rst_i = 1'b1;
		{hsel_i, hwrite_i, htrans_i, haddr_i, hwdata_i} = '0;
		hsize_i = 3'b010;
		base = 16'($urandom_range(3999, 3000));
		volts = '0;
		repeat (8) @(posedge clock_i);
		rst_i <= 1'b0;
		bus(1'b0, FWD_TH_OFS, 32'(FWD_TH_RST));
		bus(1'b0, REV_TH_OFS, 32'(REV_TH_RST));
		bus(1'b0, OVS_OFS, 32'(OVS_RST));
		bus(1'b0, ON_TIME_OFS, 32'(ON_TIME_RST));
		bus(1'b0, RELAX_OFS, 32'(RELAX_RST));
		bus(1'b0, BOARD_ID_OFS, 32'(BOARD_ID_RST));
		bus(1'b0, STATUS_OFS, 32'h0);
		bus(1'b0, 8'h3c, 32'h0);
		// Command for another board
		bus(1'b1, CTRL_OFS, 32'h0203);
		repeat (20) @(posedge clock_i);
		check("sample_req", 32'(sample_req_o), 32'h0);
		bus(1'b1, OVS_OFS, 32'h1);
		bus(1'b1, ON_TIME_OFS, 32'h1);
		bus(1'b1, RELAX_OFS, 32'h2);
		bus(1'b0, OVS_OFS, 32'h1);
		for (i = 0; i < NUM_CELLS; i++)
			set_v(i, $urandom_range(60));
		bus(1'b1, CTRL_OFS, 32'h0101);
		wait_sig(0, 1'b1, 200);
		wait_sig(0, 1'b0, 2000);
		for (i = 0; i < NUM_CELLS; i++)
			bus(1'b0, CELL_BASE_OFS + 8'(4 * i), 32'(volts[i*VOLT_W +: VOLT_W]));
		// Spread within threshold: no current
		sweep_end();
		set_v(3, 1);
		bus(1'b1, CTRL_OFS, 32'h0103);
		wait_sig(0, 1'b0, 2000);
		repeat (20) @(posedge clock_i);
		check("low_en", 32'(low_en_o), 32'h0);
		check("up_en", 32'(up_en_o), 32'h0);
		// Min and max both in lower bank
		for (i = 0; i < NUM_CELLS; i++)
			set_v(i, 0);
		set_v(2, -30);
		set_v(5, 20);
		set_v(12, 10);
		lo_q.push_back(32'h05);
		up_q.push_back(32'h18);
		rerun_cycle();
		wait_sig(1, 1'b1, 2000);
		bus(1'b0, MEAN_OFS, 32'(base));
		// Reverse request below hysteresis, forward repeat over two cycles
		for (i = 0; i < NUM_CELLS; i++)
			set_v(i, 0);
		set_v(2, 3);
		set_v(12, 12);
		up_q.push_back(32'h18);
		up_q.push_back(32'h18);
		rerun_cycle();
		wait_sig(2, 1'b1, 2000);
		wait_sig(2, 1'b0, TICK_CYCLES + 100);
		wait_sig(2, 1'b1, 2000);
		repeat (20) @(posedge clock_i);
		check("low_en", 32'(low_en_o), 32'h0);
		check("pending picks", 32'(lo_q.size() + up_q.size()), 32'h0);
		test_done();
	end
endmodule
